// ===== design/pgl_regs.vh
// Register map, field positions and reset values of the graphics port legacy GPE and VC block.
// Functional notes
// R1 - A PME on the graphics port makes an assert/deassert PME GPE message pair upstream only while control bit 2 is 1; it resets to 0.
// R2 - A hot-plug event makes assert/deassert hot-plug GPE messages upstream only while control bit 1 is 1; it resets to 0.
// R3 - While control bit 0 is 0, its reset value, received GPE assert/deassert messages are dropped.
// R4 - While control bit 0 is 1, each received GPE assert or deassert message is relayed upstream as the same kind.
// R5 - The legacy control register is at offset ECh, resets to zero, and bits 31:3 read as zero.
// R6 - The VC header reports a next-capability pointer of 140h in bits 31:20.
// R7 - The VC header version field in bits 19:16 is fixed at 1.
// R8 - The VC header bits 15:0 read the capability identifier 0002h.
// R9 - The VC header sits at offset 100h, is read-only and reads 14010002h.
// R10 - The low-priority extended VC count in bits 6:4 of VC capability 1 reads as 000.
// R11 - The extended VC count in bits 2:0 of VC capability 1 at 104h resets to 001 and is write-once.
// R12 - After the first write to the extended VC count since reset, later writes to it are ignored.
// R13 - Each enabled GPE source sends assert when its condition starts and deassert when it ends.
`ifndef PGL_REGS_VH
`define PGL_REGS_VH

`define PGL_OFS_LEGACY_CTRL   12'h0EC
`define PGL_OFS_VC_HEADER     12'h100
`define PGL_OFS_VC_CAP_ONE    12'h104

`define PGL_LEGACY_CTRL_RST   32'h00000000
`define PGL_BIT_GENERAL_EN    0
`define PGL_BIT_HOTPLUG_EN    1
`define PGL_BIT_PME_EN        2

`define PGL_VC_NEXT_PTR       12'h140
`define PGL_VC_VERSION        4'h1
`define PGL_VC_CAP_ID         16'h0002
`define PGL_VC_HEADER_VAL     32'h14010002

`define PGL_LOW_PRIORITY_VC_GROUP_COUNT        3'h0
`define PGL_EXT_VC_COUNT_RST  3'h1

`endif

// ===== design/pgl_top.v
// Configuration registers and upstream GPE message generation for the graphics attach port.
`include "pgl_regs.vh"

module pgl_top (
    input  wire        i_ref_clk,
    input  wire        i_sys_rst,
    input  wire        i_cfg_wr,
    input  wire        i_cfg_rd,
    input  wire [11:0] i_cfg_addr,
    input  wire [3:0]  i_cfg_be,
    input  wire [31:0] i_cfg_wdata,
    input  wire        i_pme_active,
    input  wire        i_hotplug_active,
    input  wire        i_gpe_assert_rx,
    input  wire        i_gpe_deassert_rx,
    output reg  [31:0] o_cfg_rdata,
    output reg         o_cfg_rd_valid,
    output reg         o_pme_event_assert_msg,
    output reg         o_pme_event_deassert_msg,
    output reg         o_hotplug_event_assert_msg,
    output reg         o_hotplug_event_deassert_msg,
    output reg         o_general_event_assert_msg,
    output reg         o_general_event_deassert_msg,
    output reg         o_pme_gpe_message_enable,
    output reg         o_hotplug_gpe_message_enable,
    output reg         o_general_gpe_forward_enable
);

    reg  [2:0]  legacy_ctrl_r;
    reg  [2:0]  ext_vc_count_r;
    reg         ext_vc_locked_r;
    reg         pme_sent_r;
    reg         hotplug_sent_r;
    reg  [31:0] rdata_nxt;

    wire        wr_legacy;
    wire        wr_cap_one;
    wire        pme_level;
    wire        hotplug_level;
    wire [31:0] legacy_ctrl_word;
    wire [31:0] vc_header_word;
    wire [31:0] vc_cap_one_word;

    assign wr_legacy  = i_cfg_wr && (i_cfg_addr == `PGL_OFS_LEGACY_CTRL) && i_cfg_be[0];
    assign wr_cap_one = i_cfg_wr && (i_cfg_addr == `PGL_OFS_VC_CAP_ONE) && i_cfg_be[0];

    // Reserved bits are constant zero rather than stored.
    assign legacy_ctrl_word = {29'h00000000, legacy_ctrl_r}; // R5
    assign vc_header_word   = {`PGL_VC_NEXT_PTR, `PGL_VC_VERSION, `PGL_VC_CAP_ID}; // R6 R7 R8 R9
    assign vc_cap_one_word  = {25'h0000000, `PGL_LOW_PRIORITY_VC_GROUP_COUNT, 1'b0, ext_vc_count_r}; // R10

    // The source level is gated by its enable, so clearing an enable while a
    // condition is active still sends the closing deassert and no GPE is left stuck.
    assign pme_level     = i_pme_active && legacy_ctrl_r[`PGL_BIT_PME_EN]; // R1
    assign hotplug_level = i_hotplug_active && legacy_ctrl_r[`PGL_BIT_HOTPLUG_EN]; // R2

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            legacy_ctrl_r <= 3'h0; // R5
        end else if (wr_legacy) begin
            legacy_ctrl_r <= i_cfg_wdata[2:0]; // R5
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ext_vc_count_r  <= `PGL_EXT_VC_COUNT_RST; // R11
            ext_vc_locked_r <= 1'b0; // R12
        end else if (wr_cap_one && !ext_vc_locked_r) begin
            ext_vc_count_r  <= i_cfg_wdata[2:0]; // R11
            ext_vc_locked_r <= 1'b1; // R12
        end
    end

    always @* begin
        rdata_nxt = 32'h00000000;
        case (i_cfg_addr)
            `PGL_OFS_LEGACY_CTRL: rdata_nxt = legacy_ctrl_word;
            `PGL_OFS_VC_HEADER:   rdata_nxt = vc_header_word;
            `PGL_OFS_VC_CAP_ONE:  rdata_nxt = vc_cap_one_word;
            default:              rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_cfg_rdata    <= 32'h00000000;
            o_cfg_rd_valid <= 1'b0;
        end else begin
            o_cfg_rd_valid <= i_cfg_rd;
            if (i_cfg_rd) begin
                o_cfg_rdata <= rdata_nxt;
            end
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            pme_sent_r                   <= 1'b0;
            hotplug_sent_r               <= 1'b0;
            o_pme_event_assert_msg       <= 1'b0;
            o_pme_event_deassert_msg     <= 1'b0;
            o_hotplug_event_assert_msg   <= 1'b0;
            o_hotplug_event_deassert_msg <= 1'b0;
            o_general_event_assert_msg   <= 1'b0;
            o_general_event_deassert_msg <= 1'b0;
        end else begin
            pme_sent_r                   <= pme_level;
            hotplug_sent_r               <= hotplug_level;
            o_pme_event_assert_msg       <= pme_level && !pme_sent_r; // R1 R13
            o_pme_event_deassert_msg     <= !pme_level && pme_sent_r; // R1 R13
            o_hotplug_event_assert_msg   <= hotplug_level && !hotplug_sent_r; // R2 R13
            o_hotplug_event_deassert_msg <= !hotplug_level && hotplug_sent_r; // R2 R13
            o_general_event_assert_msg   <= i_gpe_assert_rx &&
                                            legacy_ctrl_r[`PGL_BIT_GENERAL_EN]; // R3 R4
            o_general_event_deassert_msg <= i_gpe_deassert_rx &&
                                            legacy_ctrl_r[`PGL_BIT_GENERAL_EN]; // R3 R4
        end
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_pme_gpe_message_enable     <= 1'b0;
            o_hotplug_gpe_message_enable <= 1'b0;
            o_general_gpe_forward_enable <= 1'b0;
        end else begin
            o_pme_gpe_message_enable     <= legacy_ctrl_r[`PGL_BIT_PME_EN];
            o_hotplug_gpe_message_enable <= legacy_ctrl_r[`PGL_BIT_HOTPLUG_EN];
            o_general_gpe_forward_enable <= legacy_ctrl_r[`PGL_BIT_GENERAL_EN];
        end
    end

endmodule // pgl_top

// ===== verif/pgl_hub_model.sv
// Upstream hub model that tallies every GPE message kind it receives.
module pgl_hub_model (
    input wire       i_ref_clk,
    input wire [5:0] i_msg,
    output int       o_cnt [6]
);
    timeunit 1ns;
    timeprecision 1ns;
    // Counts are never cleared, so the bench keeps running totals across modes.
    always @(posedge i_ref_clk) for (int k = 0; k < 6; k++) o_cnt[k] <= o_cnt[k] + i_msg[k];
endmodule // pgl_hub_model

// ===== verif/pgl_sva.sv
// Port checker for the graphics port legacy GPE block.
module pgl_sva (
    input wire        i_ref_clk,
    input wire        i_sys_rst,
    input wire        i_cfg_rd,
    input wire [11:0] i_cfg_addr,
    input wire [31:0] o_cfg_rdata,
    input wire        o_cfg_rd_valid,
    input wire        i_gpe_assert_rx,
    input wire        o_general_event_assert_msg,
    input wire        o_general_gpe_forward_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_vc_header: assert property (i_cfg_rd && i_cfg_addr == 12'h100
        |=> o_cfg_rdata == 32'h14010002) else $error("Bad header.");
    a_vc_cap_one: assert property (i_cfg_rd && i_cfg_addr == 12'h104
        |=> o_cfg_rdata[31:3] == 29'h0) else $error("Bad VC count.");
    a_ctrl_reserved: assert property (i_cfg_rd && i_cfg_addr == 12'h0EC
        |=> o_cfg_rdata[31:3] == 29'h0) else $error("Bad reserved bits.");
    a_read_answer: assert property (i_cfg_rd |=> o_cfg_rd_valid) else $error("No answer.");
    a_answer_cause: assert property (o_cfg_rd_valid |-> $past(i_cfg_rd)) else $error("Stray.");
    // The enable copy lags the register by one cycle, so it is sampled one cycle on.
    a_gpe_relay: assert property (i_gpe_assert_rx ##1 o_general_gpe_forward_enable
        |-> o_general_event_assert_msg) else $error("GPE not relayed.");
    a_gpe_drop: assert property (i_gpe_assert_rx ##1 !o_general_gpe_forward_enable
        |-> !o_general_event_assert_msg) else $error("GPE not dropped.");
    a_relay_cause: assert property (o_general_event_assert_msg
        |-> $past(i_gpe_assert_rx) && o_general_gpe_forward_enable) else $error("Stray GPE.");
endmodule // pgl_sva
bind pgl_top pgl_sva checker_inst (.*);

// ===== verif/testbench.sv
// Self-checking bench for the graphics port legacy GPE block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_ref_clk = 0, i_sys_rst = 1, i_cfg_wr = 0, i_cfg_rd = 0, i_pme_active = 0;
    logic        i_hotplug_active = 0, i_gpe_assert_rx = 0, i_gpe_deassert_rx = 0;
    logic [3:0]  i_cfg_be = 0;
    logic [11:0] i_cfg_addr = 0;
    logic [31:0] i_cfg_wdata = 0, d;
    wire  [31:0] o_cfg_rdata;
    wire         o_cfg_rd_valid, o_pme_gpe_message_enable, o_hotplug_gpe_message_enable;
    wire         o_general_gpe_forward_enable, o_pme_event_assert_msg, o_pme_event_deassert_msg;
    wire         o_hotplug_event_assert_msg, o_hotplug_event_deassert_msg;
    wire         o_general_event_assert_msg, o_general_event_deassert_msg;
    int          cnt [6], want [6], miscompares = 0, compares = 0;
    pgl_top dut (.*);
    pgl_hub_model hub (.i_ref_clk, .o_cnt(cnt), .i_msg({o_general_event_deassert_msg,
        o_general_event_assert_msg, o_hotplug_event_deassert_msg, o_hotplug_event_assert_msg,
        o_pme_event_deassert_msg, o_pme_event_assert_msg}));
    always #20 i_ref_clk = ~i_ref_clk;
    task automatic chk(logic [32:0] e, logic [32:0] g);
        compares++;
        miscompares += (g !== e);
        if (g !== e) $display("unexpected at %0t: expected %h got %h", $time, e, g);
    endtask
    // Reads carry the expected word in v; the answer is looked at while it stands.
    task automatic acc(logic w, logic [11:0] a, logic [31:0] v, logic [3:0] be);
        @(negedge i_ref_clk);
        {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_wdata, i_cfg_be} = {w, !w, a, v, be};
        @(negedge i_ref_clk) {i_cfg_wr, i_cfg_rd} = 2'h0;
        if (!w) chk({1'b1, v}, {o_cfg_rd_valid, o_cfg_rdata});
    endtask
    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(70963));
        #120 i_sys_rst = 0;
        d = $urandom;
        acc(0, 12'h0EC, 32'h0, 4'h0);
        acc(0, 12'h104, 32'h1, 4'h0);
        acc(1, 12'h100, d, 4'hF);
        acc(0, 12'h100, 32'h14010002, 4'h0);
        acc(1, 12'h104, d, 4'h1);
        acc(1, 12'h104, ~d, 4'h1);
        acc(0, 12'h104, {29'h0, d[2:0]}, 4'h0);
        acc(1, 12'h0EC, 32'h7, 4'h0);
        acc(0, 12'h0EC, 32'h0, 4'h0);
        $display("register test done");
        for (int c = 0; c < 8; c++) begin
            acc(1, 12'h0EC, $urandom & ~32'h7 | c, 4'h1);
            acc(0, 12'h0EC, c, 4'h0);
            chk(33'(c), 33'({o_pme_gpe_message_enable, o_hotplug_gpe_message_enable,
                o_general_gpe_forward_enable}));
            {i_pme_active, i_hotplug_active, i_gpe_assert_rx} = 3'h7;
            @(negedge i_ref_clk) {i_gpe_assert_rx, i_gpe_deassert_rx} = 2'h1;
            @(negedge i_ref_clk) {i_gpe_deassert_rx, i_pme_active, i_hotplug_active} = 3'h0;
            repeat (2) @(negedge i_ref_clk);
            for (int k = 0; k < 6; k++) begin
                want[k] += c[2 - k / 2];
                chk(33'(want[k]), 33'(cnt[k]));
            end
        end
        $display("event test done");
        // Clearing the enable while the PME condition is still active must close the pair.
        i_pme_active = 1;
        acc(1, 12'h0EC, 32'h0, 4'h1);
        repeat (2) @(negedge i_ref_clk);
        i_pme_active = 0;
        for (int k = 0; k < 2; k++) chk(33'(++want[k]), 33'(cnt[k]));
        $display("enable clear test done");
        end_of_test();
    end
endmodule // testbench
